/* fpec_ctrl.sv */
// flash program and erase control: unlock, status, guard, page select
//
// Decided for this implementation: the Wishbone register port.
module fpec_ctrl #(
    parameter int PROG_CYCLES = fpec_pkg::PROG_CYCLES,
    parameter int ERASE_STEP  = 1
) (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // classic wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [25:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    output logic                        wb_err_o,
    // user program memory port, same clock
    input  wire logic                   pm_wr,
    input  wire logic [23:0]            pm_addr,
    input  wire logic [1:0]             pm_be,
    input  wire logic [15:0]            pm_wdata,
    input  wire logic                   pm_rd,
    output logic      [15:0]            pm_rdata,
    output logic                        pm_wait,
    // flash array side
    output fpec_pkg::fpec_array_req_s   array_req,
    input  wire logic [15:0]            array_rdata,
    input  wire logic [15:0]            extra_area_select_rdata
);
    // bus decode
    logic        acc;
    logic        hit_cmd;
    logic        hit_ctl;
    logic        hit_grd;
    logic        hit_pag;
    logic        mapped;
    logic        wr_lane0;
    logic        wr_lane1;

    // state registers and their next values
    fpec_pkg::fpec_lock_e  lock_st;
    fpec_pkg::fpec_lock_e  next_lock_st;
    fpec_pkg::fpec_op_e    op_st;
    fpec_pkg::fpec_op_e    next_op_st;
    logic                  extra_area_select;
    logic                  next_extra_area_select;
    logic [7:0]            sector_guard;
    logic [7:0]            next_sector_guard;
    logic [5:0]            page_choice;
    logic [5:0]            next_page_choice;
    logic [5:0]            operation_state_field;
    logic [5:0]            next_operation_state_field;
    logic [31:0]           op_count;
    logic [31:0]           next_op_count;
    logic [10:0]           erase_idx;
    logic [10:0]           next_erase_idx;
    logic [15:0]           hold_word;
    logic [15:0]           next_hold_word;
    logic [1:0]            hold_be;
    logic [1:0]            next_hold_be;
    logic [22:0]           hold_addr;
    logic [22:0]           next_hold_addr;
    logic                  ack;
    logic                  next_ack;
    logic                  err;
    logic                  next_err;
    logic [31:0]           rdat;
    logic [31:0]           next_rdat;
    logic [15:0]           pm_rdata_q;
    logic [15:0]           next_pm_rdata;
    fpec_pkg::fpec_array_req_s next_array_req;

    // page and sector checks for user writes
    logic        in_page;
    logic        page_guarded;
    logic [2:0]  page_sector;
    logic [7:0]  cmd;

    // one request per cycle; ack drops the cycle after it is given
    assign acc      = wb_cyc_i && wb_stb_i && !ack && !err;
    assign wr_lane0 = wb_sel_i[0];
    assign wr_lane1 = wb_sel_i[1];
    assign cmd      = wb_dat_i[7:0];

    // address decode
    always_comb
    begin
        hit_cmd = 1'b0;
        hit_ctl = 1'b0;
        hit_grd = 1'b0;
        hit_pag = 1'b0;
        if (wb_adr_i == fpec_pkg::ADR_CMD_STATE)
            hit_cmd = 1'b1;
        else if (wb_adr_i == fpec_pkg::ADR_CONTROL)
            hit_ctl = 1'b1;
        else if (wb_adr_i == fpec_pkg::ADR_GUARD)
            hit_grd = 1'b1;
        else if (wb_adr_i == fpec_pkg::ADR_PAGE)
            hit_pag = 1'b1;
        mapped = hit_cmd || hit_ctl || hit_grd || hit_pag;
    end

    // eight sectors of eight pages each
    assign page_sector  = page_choice[5:3];
    assign page_guarded = sector_guard[page_sector];
    assign in_page = (pm_addr[fpec_pkg::PADDR_HI:fpec_pkg::PADDR_LO]
                      == page_choice);

    // next state for lock sequence, operations and registers
    always_comb
    begin
        next_lock_st               = lock_st;
        next_op_st                 = op_st;
        next_extra_area_select     = extra_area_select;
        next_sector_guard          = sector_guard;
        next_page_choice           = page_choice;
        next_operation_state_field = operation_state_field;
        next_op_count              = op_count;
        next_erase_idx             = erase_idx;
        next_hold_word             = hold_word;
        next_hold_be               = hold_be;
        next_hold_addr             = hold_addr;
        next_ack                   = 1'b0;
        next_err                   = 1'b0;
        next_rdat                  = rdat;
        next_array_req             = '0;

        // register access over the bus
        if (acc && !mapped)
            next_err = 1'b1;
        else if (acc)
        begin
            next_ack  = 1'b1;
            next_rdat = 32'h0000_0000;
            if (!wb_we_i)
            begin
                // reads never change controller state
                if (hit_cmd)
                    next_rdat[7:0] = {lock_st == fpec_pkg::FPEC_OPEN,
                                      1'b0,
                                      operation_state_field};
                else if (hit_ctl)
                    next_rdat[7:0] = {extra_area_select, 7'h00};
                else if (hit_grd)
                    next_rdat[7:0] = sector_guard;
                else
                    next_rdat[15:0] = {7'h00, page_choice, 3'h0};
            end
            else if (hit_cmd && wr_lane0)
            begin
                // command decode; anything unexpected relocks
                next_lock_st = fpec_pkg::FPEC_LOCKED;
                if (op_st == fpec_pkg::FPEC_IDLE)
                begin
                    if (lock_st == fpec_pkg::FPEC_LOCKED
                        && cmd == fpec_pkg::CMD_UNLOCK1)
                        next_lock_st = fpec_pkg::FPEC_HALF;
                    else if (lock_st == fpec_pkg::FPEC_HALF
                             && cmd == fpec_pkg::CMD_UNLOCK2)
                        next_lock_st = fpec_pkg::FPEC_OPEN;
                    else if (lock_st == fpec_pkg::FPEC_OPEN
                             && cmd == fpec_pkg::CMD_PAGE_ERASE
                             && !page_guarded)
                    begin
                        // erase keeps the unlock until it finishes
                        next_lock_st   = fpec_pkg::FPEC_OPEN;
                        next_op_st     = fpec_pkg::FPEC_ERASE;
                        next_erase_idx = 11'h000;
                        next_operation_state_field =
                            fpec_pkg::ST_PERASE;
                    end
                    // mass erase from user code only relocks
                end
            end
            else if (hit_ctl && wr_lane0)
                next_extra_area_select = wb_dat_i[fpec_pkg::CTRL_EXTRA_AREA_SELECT_BIT];
            else if (hit_grd && wr_lane0)
                next_sector_guard = sector_guard | wb_dat_i[7:0];
            else if (hit_pag && wr_lane0)
            begin
                // a page write while mid-sequence breaks the unlock
                next_page_choice = wb_dat_i[fpec_pkg::PAGE_HI:
                                            fpec_pkg::PAGE_LO];
                if (lock_st != fpec_pkg::FPEC_LOCKED)
                    next_lock_st = fpec_pkg::FPEC_LOCKED;
            end
            else if (hit_pag && wr_lane1)
            begin
                if (lock_st != fpec_pkg::FPEC_LOCKED)
                    next_lock_st = fpec_pkg::FPEC_LOCKED;
            end
        end

        // array operations
        case (op_st)
            fpec_pkg::FPEC_IDLE:
            begin
                // byte writes merge until both halves of a word are in
                if (pm_wr && lock_st == fpec_pkg::FPEC_OPEN && in_page
                    && !page_guarded)
                begin
                    if (pm_be[0])
                        next_hold_word[7:0] = pm_wdata[7:0];
                    if (pm_be[1])
                        next_hold_word[15:8] = pm_wdata[15:8];
                    next_hold_addr = pm_addr[23:1];
                    next_hold_be   = hold_be | pm_be;
                    if ((hold_be | pm_be) == 2'b11)
                    begin
                        next_hold_be  = 2'b00;
                        next_op_st    = fpec_pkg::FPEC_PROG;
                        next_op_count = 32'h0000_0000;
                        next_operation_state_field =
                            fpec_pkg::ST_PROG;
                    end
                end
            end
            fpec_pkg::FPEC_PROG:
            begin
                next_array_req.prog = (op_count == 32'h0000_0000);
                next_array_req.addr = hold_addr;
                next_array_req.data = hold_word;
                next_op_count = op_count + 32'h0000_0001;
                if (op_count >= 32'(PROG_CYCLES - 1))
                begin
                    next_op_st = fpec_pkg::FPEC_IDLE;
                    next_operation_state_field = fpec_pkg::ST_IDLE;
                end
            end
            fpec_pkg::FPEC_ERASE:
            begin
                // writes all-ones over the selected page, one word every ERASE_STEP words
                next_array_req.page_erase = 1'b1;
                next_array_req.addr = {6'h00, page_choice, erase_idx};
                next_array_req.data = fpec_pkg::ERASED_WORD;
                next_erase_idx = erase_idx + 11'(ERASE_STEP);
                if (erase_idx == 11'(fpec_pkg::PAGE_WORDS - ERASE_STEP))
                begin
                    next_op_st   = fpec_pkg::FPEC_IDLE;
                    next_lock_st = fpec_pkg::FPEC_LOCKED;
                    next_operation_state_field = fpec_pkg::ST_IDLE;
                end
            end
            default:
                next_op_st = fpec_pkg::FPEC_IDLE;
        endcase
    end

    // data reads: information area overlay, held in wait while busy
    always_comb
    begin
        next_pm_rdata = pm_rdata_q;
        if (pm_rd && op_st == fpec_pkg::FPEC_IDLE)
        begin
            if (extra_area_select && pm_addr <= fpec_pkg::EXTRA_AREA_SELECT_LAST)
                next_pm_rdata = extra_area_select_rdata;
            else
                next_pm_rdata = array_rdata;
        end
    end

    // registers; reset always relocks
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            lock_st               <= fpec_pkg::FPEC_LOCKED;
            op_st                 <= fpec_pkg::FPEC_IDLE;
            extra_area_select     <= fpec_pkg::CONTROL_RST[7];
            sector_guard          <= fpec_pkg::GUARD_RST;
            page_choice           <= fpec_pkg::PAGE_RST;
            operation_state_field <= fpec_pkg::ST_IDLE;
            op_count              <= 32'h0000_0000;
            erase_idx             <= 11'h000;
            hold_word             <= 16'hffff;
            hold_be               <= 2'b00;
            hold_addr             <= 23'h000000;
            ack                   <= 1'b0;
            err                   <= 1'b0;
            rdat                  <= 32'h0000_0000;
            pm_rdata_q            <= 16'h0000;
            array_req             <= '0;
        end
        else
        begin
            lock_st               <= next_lock_st;
            op_st                 <= next_op_st;
            extra_area_select     <= next_extra_area_select;
            sector_guard          <= next_sector_guard;
            page_choice           <= next_page_choice;
            operation_state_field <= next_operation_state_field;
            op_count              <= next_op_count;
            erase_idx             <= next_erase_idx;
            hold_word             <= next_hold_word;
            hold_be               <= next_hold_be;
            hold_addr             <= next_hold_addr;
            ack                   <= next_ack;
            err                   <= next_err;
            rdat                  <= next_rdat;
            pm_rdata_q            <= next_pm_rdata;
            array_req             <= next_array_req;
        end
    end

    // outputs
    assign wb_ack_o = ack;
    assign wb_err_o = err;
    assign wb_dat_o = rdat;
    assign pm_rdata = pm_rdata_q;
    assign pm_wait  = (op_st != fpec_pkg::FPEC_IDLE);
endmodule

/* fpec_ctrl_asserts.sv */
// checker for bus timing, reserved bits and array requests of fpec_ctrl
module fpec_ctrl_asserts (
    input wire logic                      clock,
    input wire logic                      sys_rst,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [25:0]               wb_adr_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [31:0]               wb_dat_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      wb_err_o,
    input wire logic                      pm_wr,
    input wire logic                      pm_wait,
    input wire fpec_pkg::fpec_array_req_s array_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic       take;
    logic [5:0] page_seen;
    logic [5:0] next_page_seen;

    // a request is taken on an edge where no answer is showing
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // shadow of the page field, so erase addresses can be judged
    always_comb
    begin
        next_page_seen = page_seen;
        if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == fpec_pkg::ADR_PAGE)
            next_page_seen = wb_dat_i[8:3];
    end

    always_ff @(posedge clock)
    begin
        page_seen <= sys_rst ? 6'h00 : next_page_seen;
    end

    sequence s_read(logic [25:0] a);
        take && !wb_we_i && wb_adr_i == a;
    endsequence

    a_answer_next: assert property (take |=> wb_ack_o ^ wb_err_o)
        else $error("bus request not answered one cycle later");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_status_bit6: assert property (
        s_read(fpec_pkg::ADR_CMD_STATE) |=> wb_ack_o && !wb_dat_o[6])
        else $error("status read refused or bit 6 set");
    a_ctrl_low_zero: assert property (
        s_read(fpec_pkg::ADR_CONTROL) |=> wb_dat_o[6:0] == 7'h00)
        else $error("control bits 6..0 not zero");
    a_page_rsvd_zero: assert property (
        s_read(fpec_pkg::ADR_PAGE) |=>
        wb_dat_o[15:9] == 7'h00 && wb_dat_o[2:0] == 3'h0)
        else $error("page select reserved bits not zero");
    a_idle_state: assert property (
        s_read(fpec_pkg::ADR_CMD_STATE) ##0 (!pm_wait && !pm_wr)
        |=> wb_dat_o[5:0] == 6'h00)
        else $error("state field not idle while no operation runs");
    a_no_mass_erase: assert property (!array_req.mass_erase)
        else $error("mass erase sent to the array");
    a_erase_word: assert property (array_req.page_erase |->
        array_req.data == fpec_pkg::ERASED_WORD &&
        array_req.addr[16:11] == page_seen)
        else $error("erase word not all ones or outside selected page");
    a_reset_quiet: assert property ($fell(sys_rst) |->
        !pm_wait && !wb_ack_o && !array_req.prog)
        else $error("block busy right after reset");
    a_wait_ends: assert property (
        $rose(pm_wait) |-> ##[1:1000] !pm_wait)
        else $error("operation never finished");
endmodule

bind fpec_ctrl fpec_ctrl_asserts fpec_ctrl_asserts_inst (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pm_wr(pm_wr),
    .pm_wait(pm_wait), .array_req(array_req));

/* fpec_ctrl_tb_top.sv */
// self-checking testbench for the flash program and erase control block
module fpec_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          PCYC  = 8;
    localparam int          ESTEP = 256;
    localparam logic [25:0] A_CMD = fpec_pkg::ADR_CMD_STATE;
    localparam logic [25:0] A_CTL = fpec_pkg::ADR_CONTROL;
    localparam logic [25:0] A_GRD = fpec_pkg::ADR_GUARD;
    localparam logic [25:0] A_PG  = fpec_pkg::ADR_PAGE;

    logic                      clock    = 1'b0;
    logic                      sys_rst  = 1'b1;
    logic                      wb_cyc_i = 1'b0;
    logic                      wb_stb_i = 1'b0;
    logic                      wb_we_i  = 1'b0;
    logic [25:0]               wb_adr_i = 26'h0;
    logic [3:0]                wb_sel_i = 4'hf;
    logic [31:0]               wb_dat_i = 32'h0;
    logic [31:0]               wb_dat_o;
    logic                      wb_ack_o;
    logic                      wb_err_o;
    logic                      pm_wr    = 1'b0;
    logic [23:0]               pm_addr  = 24'h0;
    logic [1:0]                pm_be    = 2'b11;
    logic [15:0]               pm_wdata = 16'h0;
    logic                      pm_rd    = 1'b0;
    logic [15:0]               pm_rdata;
    logic                      pm_wait;
    fpec_pkg::fpec_array_req_s array_req;
    logic [15:0]               array_rdata;
    logic [15:0]               extra_area_select_rdata;
    logic [15:0]               prog_data;
    int                        prog_count;
    int                        erase_count;
    int                        mass_count;
    int                        miscompares = 0;
    int                        checked = 0;
    logic                      last_err;

    fpec_ctrl #(.PROG_CYCLES(PCYC), .ERASE_STEP(ESTEP)) fpec_ctrl_inst (
        .clock, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pm_wr,
        .pm_addr, .pm_be, .pm_wdata, .pm_rd, .pm_rdata, .pm_wait,
        .array_req, .array_rdata, .extra_area_select_rdata);
    fpec_flash_model fpec_flash_model_inst (.clock, .pm_addr, .array_req,
        .array_rdata, .extra_area_select_rdata, .prog_count, .erase_count, .mass_count,
        .prog_data);

    always #5 clock = ~clock;

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // classic single cycle: hold everything until ack or err is sampled
    task automatic wb(input logic w, input logic [25:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 64);
        if (n == 64)
            miscompares++;
        last_err = wb_err_o;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [25:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [25:0] a, input logic [31:0] e,
                       input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        cmp(what, e, q);
    endtask

    task automatic unlock();
        wr(A_CMD, 32'h73);
        wr(A_CMD, 32'h8c);
    endtask

    task automatic pm_write(input logic [23:0] a, input logic [15:0] d);
        @(posedge clock);
        pm_wr <= 1'b1;
        pm_addr <= a;
        pm_wdata <= d;
        @(posedge clock);
        pm_wr <= 1'b0;
    endtask

    // read data lands with the edge that takes the strobe
    task automatic pm_read(input logic [23:0] a, input logic [15:0] e,
                           input string what);
        @(posedge clock);
        pm_rd <= 1'b1;
        pm_addr <= a;
        @(posedge clock);
        pm_rd <= 1'b0;
        #1 cmp(what, e, pm_rdata);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (pm_wait !== 1'b0 && n < 5000)
        begin
            @(posedge clock);
            #1 n++;
        end
        if (n == 5000)
            miscompares++;
    endtask

    task automatic t_reset();
        logic [31:0] q;
        rdc(A_CMD, 32'h00, "status");
        rdc(A_CTL, 32'h00, "control");
        rdc(A_GRD, 32'h00, "guard");
        rdc(A_PG, 32'h00, "page");
        wb(1'b0, 26'h0000010, 32'h0, q);
        cmp("unmapped error", 32'h1, {31'h0, last_err});
        wr(A_PG, 32'h0000ffff);
        rdc(A_PG, 32'h000001f8, "page reserved");
    endtask

    task automatic t_unlock();
        logic [7:0] bad [3] = '{8'h00, 8'h5a, 8'h63};
        wr(A_CMD, 32'h73);
        rdc(A_CMD, 32'h00, "half unlocked");
        wr(A_CMD, 32'h8c);
        rdc(A_CMD, 32'h80, "unlocked");
        wr(A_CMD, 32'h8c);
        rdc(A_CMD, 32'h00, "second code alone");
        wr(A_CMD, 32'h73);
        unlock();
        rdc(A_CMD, 32'h00, "repeated first code");
        foreach (bad[i])
        begin
            unlock();
            wr(A_CMD, {24'h0, bad[i]});
            rdc(A_CMD, 32'h00, "relocked");
        end
        cmp("mass erases", 32'h0, mass_count);
        unlock();
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        rdc(A_CMD, 32'h00, "status after reset");
    endtask

    task automatic t_extra_area_select();
        wr(A_CTL, 32'h80);
        rdc(A_CTL, 32'h80, "control");
        pm_read(24'h00007f, 16'hc37f, "extra_area_select top");
        pm_read(24'h000080, 16'h5a80, "main above extra_area_select");
        wr(A_CTL, 32'h00);
        pm_read(24'h000010, 16'h5a10, "main low");
    endtask

    task automatic t_program();
        logic [31:0] q;
        int          pc;
        pc = prog_count;
        wr(A_PG, 32'h0028);
        unlock();
        pm_write(24'h002810, 16'h1234);
        wb(1'b0, A_CMD, 32'h0, q);
        cmp("program state", 32'h08, q & 32'h38);
        wait_idle();
        cmp("program count", pc + 1, prog_count);
        cmp("program data", 32'h1234, {16'h0, prog_data});
        pm_write(24'h003010, 16'h4321);
        wait_idle();
        cmp("stray program", pc + 1, prog_count);
        wr(A_CMD, 32'h00);
    endtask

    // erase of an open page, then guarded sector refuses both operations
    task automatic t_erase_guard();
        logic [31:0] q;
        int          ec;
        int          pc;
        ec = erase_count;
        wr(A_PG, 32'h0048);
        unlock();
        wr(A_CMD, 32'h95);
        wb(1'b0, A_CMD, 32'h0, q);
        cmp("erase state", 32'h10, q & 32'h3f);
        wait_idle();
        rdc(A_CMD, 32'h00, "after erase");
        cmp("erase words", ec + 2048 / ESTEP, erase_count);
        wr(A_GRD, 32'h01);
        wr(A_GRD, 32'h04);
        wr(A_GRD, 32'h00);
        rdc(A_GRD, 32'h05, "guard");
        ec = erase_count;
        pc = prog_count;
        wr(A_PG, 32'h0008);
        unlock();
        pm_write(24'h000810, 16'h0f0f);
        wait_idle();
        wr(A_CMD, 32'h95);
        wait_idle();
        cmp("guarded program", pc, prog_count);
        cmp("guarded erase", ec, erase_count);
        rdc(A_CMD, 32'h00, "guarded erase status");
    endtask

    // watchdog: the tests need a few hundred cycles, this allows 20000
    initial
    begin
        #200000;
        miscompares++;
        conclude();
    end

    initial
    begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_unlock();
        t_extra_area_select();
        t_program();
        t_erase_guard();
        conclude();
    end
endmodule

/* fpec_flash_model.sv */
// behavioural flash array: read patterns and a log of program and erase
module fpec_flash_model (
    input  wire logic                      clock,
    input  wire logic [23:0]               pm_addr,
    input  wire fpec_pkg::fpec_array_req_s array_req,
    output logic      [15:0]               array_rdata,
    output logic      [15:0]               extra_area_select_rdata,
    output int                             prog_count,
    output int                             erase_count,
    output int                             mass_count,
    output logic      [15:0]               prog_data
);
    // distinct patterns per area, so a wrong overlay pick shows at once
    assign array_rdata = {8'h5a, pm_addr[7:0]};
    assign extra_area_select_rdata  = {8'hc3, pm_addr[7:0]};

    initial
    begin
        prog_count = 0;
        erase_count = 0;
        mass_count = 0;
        prog_data = 16'h0000;
    end

    // log every pulse toward the cells; only all-ones erase words count
    always @(posedge clock)
    begin
        if (array_req.prog === 1'b1)
        begin
            prog_count++;
            prog_data = array_req.data;
        end
        if (array_req.page_erase === 1'b1 && array_req.data === 16'hffff)
            erase_count++;
        if (array_req.mass_erase === 1'b1)
            mass_count++;
    end
endmodule

/* fpec_pkg.sv */
// package: register map, command codes, field layout and timing for the flash control block
package fpec_pkg;
    // register indices; the bus byte address of each is four times its index
    localparam logic [23:0] IDX_CMD_STATE = 24'hffe060;
    localparam logic [23:0] IDX_CONTROL   = 24'hffe061;
    localparam logic [23:0] IDX_GUARD     = 24'hffe062;
    localparam logic [23:0] IDX_PAGE      = 24'hffe064;
    localparam int          ADDR_W        = 26;
    localparam logic [25:0] ADR_CMD_STATE = {IDX_CMD_STATE, 2'b00};
    localparam logic [25:0] ADR_CONTROL   = {IDX_CONTROL, 2'b00};
    localparam logic [25:0] ADR_GUARD     = {IDX_GUARD, 2'b00};
    localparam logic [25:0] ADR_PAGE      = {IDX_PAGE, 2'b00};

    // command codes
    localparam logic [7:0] CMD_UNLOCK1    = 8'h73;
    localparam logic [7:0] CMD_UNLOCK2    = 8'h8c;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h63;

    // status field encodings
    localparam logic [5:0] ST_IDLE  = 6'h00;
    localparam logic [5:0] ST_PROG  = 6'h08;
    localparam logic [5:0] ST_PERASE = 6'h10;
    localparam logic [5:0] ST_MERASE = 6'h20;
    localparam int         STAT_UNLOCK_BIT = 7;
    localparam int         CTRL_EXTRA_AREA_SELECT_BIT   = 7;

    // page select layout and page geometry
    localparam int PAGE_LO    = 3;
    localparam int PAGE_HI    = 8;
    localparam int PADDR_LO   = 11;
    localparam int PADDR_HI   = 16;
    localparam int PAGE_WORDS = 2048;
    localparam int SECTORS    = 8;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // information area window in program byte addresses
    localparam logic [23:0] EXTRA_AREA_SELECT_LAST = 24'h00007f;

    // reset values
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [7:0]  GUARD_RST   = 8'h00;
    localparam logic [5:0]  PAGE_RST    = 6'h00;

    // timing of array operations
    localparam int CLK_MHZ       = 100;
    localparam int PROG_TIME_US  = 40;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;

    // unlock sequence states
    typedef enum logic [1:0] {
        FPEC_LOCKED,
        FPEC_HALF,
        FPEC_OPEN
    } fpec_lock_e;

    // operation states
    typedef enum logic [1:0] {
        FPEC_IDLE,
        FPEC_PROG,
        FPEC_ERASE
    } fpec_op_e;

    // request toward the flash array
    typedef struct packed {
        logic        prog;
        logic        page_erase;
        logic        mass_erase;
        logic [22:0] addr;
        logic [15:0] data;
    } fpec_array_req_s;
endpackage
